// ---- src/wpc_pkg.sv ----
// constants and types for the write precompensation and test-mode controller
`default_nettype none
package wpc_pkg;
  // register map
  localparam logic [31:0] WPC_CTRL_ADDR = 32'h0000_0000;
  localparam logic [31:0] WPC_STATUS_ADDR = 32'h0000_0004;
  localparam logic [31:0] WPC_WORD_MASK = 32'hFFFF_FFFC;
  localparam int WPC_CTRL_MFM_BIT = 0;
  localparam int WPC_CTRL_PTAP_LSB = 4;
  localparam logic WPC_CTRL_MFM_RESET = 1'h0;
  localparam logic [3:0] WPC_CTRL_PTAP_RESET = 4'h4;
  localparam int WPC_ST_MODE_LSB = 0;
  localparam int WPC_ST_VCOEXT_BIT = 3;
  localparam int WPC_ST_SYNC_BIT = 4;
  localparam int WPC_ST_WRITE_GATE_BIT = 5;
  localparam int WPC_ST_CNT_LSB = 8;
  localparam logic [1:0] WPC_HTRANS_NONSEQ = 2'h2;
  // synchronised pin vector positions
  localparam int WPC_IN_WDATA = 0;
  localparam int WPC_IN_EARLY = 1;
  localparam int WPC_IN_LATE = 2;
  localparam int WPC_IN_DSHIFT = 3;
  localparam int WPC_IN_WRITE_GATE = 4;
  localparam int WPC_IN_READ_GATE = 5;
  localparam int WPC_IN_PCEN = 6;
  localparam int WPC_IN_TSEL = 7;
  localparam int WPC_IN_RAW = 8;
  localparam int WPC_IN_CRG = 9;
  localparam int WPC_IN_PHASE_LOCK_FLAG = 10;
  localparam int WPC_IN_FUP = 11;
  localparam int WPC_IN_FDN = 12;
  localparam int WPC_IN_W = 13;
  // delay line taps
  localparam int WPC_DL_TAPS = 16;
  localparam logic [3:0] WPC_TAP_NOMINAL = 4'h8;
  localparam logic [3:0] WPC_TAP_ONE = 4'h1;
  localparam logic [3:0] WPC_TAP_TWO = 4'h2;
  localparam logic [1:0] WPC_SUPPRESS_AT = 2'h2;
  localparam logic [1:0] WPC_CNT_MAX = 2'h3;
  // test modes decoded from {early, late, enable}
  typedef enum logic [2:0] {
    WPC_TM_NORMAL = 3'b000,
    WPC_TM_PHASE_DET = 3'b001,
    WPC_TM_PUMP_UP_PD = 3'b010,
    WPC_TM_PUMP_UP = 3'b011,
    WPC_TM_PUMP_DN_PD = 3'b100,
    WPC_TM_PUMP_DN = 3'b101,
    WPC_TM_OPTICAL = 3'b110,
    WPC_TM_ACQ_SEQ = 3'b111
  } wpc_mode_e;
endpackage : wpc_pkg
`default_nettype wire

// ---- src/wpc_ctrl.sv ----
// write precompensation, pulse former and test-mode control with an AHB-Lite slave
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// [R1] capture write data, early, late, double shift on both write clock edges
// [R2] retime captured write inputs on one crystal clock edge
// [R3] with write gate high, write data goes through the delay line
// [R4] precomp enable low selects the nominal tap
// [R5] enabled: early picks early tap, late picks late tap, double shift sets size
// [R6] neither or both shift requests select the nominal tap
// [R7] shift is one stage, or two stages with double shift
// [R8] in MFM soft sector, the third output pulse of a write is suppressed
// [R9] sixteen equal taps span one crystal period; here each tap is one crystal clock, so the line spans sixteen
// [R10] raw read rising edge starts a pulse ended by a tap count
// [R11] reset puts every flip-flop in a known state
// [R12] write clock is crystal clock divided by two, phase set by sync
// [R13] shifts low, write gate high: enable pulse makes internal reset pulse
// [R14] reset pulse forces clocks high, clears divider, halts oscillator, pump off
// [R15] controller keeps read gate low at enable fall for plain sync
// [R16] controller holds enable high at least five crystal clocks for VCO select
// [R17] at enable fall, read gate level latches external or internal VCO
// [R18] external VCO: clock from test select, which then decodes as low
// [R19] test select low decodes early, late, enable into test modes
// [R20] acquisition mode routes composite read gate and phase lock flag out
// [R21] optical mode runs the read clock at twice the data rate
// [R22] phase detector mode puts up error on read data, down on read clock
// [R23] pump modes block data, force direction, open feedback, defeat clamp
// [R24] write gate low holds output idle and restarts the pulse count
module wpc_ctrl
  import wpc_pkg::*;
#(
  parameter int TAPS = WPC_DL_TAPS
) (
  input wire logic sys_clk, // crystal clock, 50 MHz
  input wire logic reset, // synchronous, active high
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic write_data_in, // controller write data
  input wire logic early_req, // early shift request
  input wire logic late_req, // late shift request
  input wire logic double_shift_sel, // two-stage shift
  input wire logic write_gate, // write gate
  input wire logic read_gate, // read gate
  input wire logic precomp_enable, // precompensation enable
  input wire logic test_select, // test select, high is normal
  input wire logic raw_read_in, // raw read data
  input wire logic composite_read_gate, // from acquisition sequencer
  input wire logic phase_lock_flag, // from acquisition sequencer
  input wire logic freq_up_err, // phase detector up error
  input wire logic freq_down_err, // phase detector down error
  output logic write_clock_out, // crystal clock divided by two
  output logic precomp_write_out, // precompensated write data
  output logic read_data_out, // read data or test signal
  output logic read_clock_out, // read clock or test signal
  output logic vco_external, // external VCO selected
  output logic ext_vco_clock, // VCO clock taken from test select
  output logic vco_div_clear, // clear VCO divider
  output logic ring_osc_halt, // halt ring oscillator
  output logic phase_det_reset, // reset phase detector
  output logic pump_tristate, // tristate charge pump
  output logic velocity_lock_state, // force velocity lock
  output logic pd_data_block, // block data to phase detector
  output logic pump_force_up, // constant pump up
  output logic pump_force_down, // constant pump down
  output logic pump_feedback_open, // open pump to control feedback
  output logic pump_clamp_defeat // defeat pump clamp
);

  if (TAPS != 16) begin : g_taps_check
    $error("wpc_ctrl: tap select logic serves exactly sixteen taps");
  end

  function automatic logic is_reg(input logic [31:0] addr, input logic [31:0] off);
    is_reg = (addr & WPC_WORD_MASK) == off;
  endfunction : is_reg

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [WPC_IN_W-1:0] sync1, sync2, next_sync1, next_sync2;
  logic [3:0] wr_cap, wr_rt, next_wr_cap, next_wr_rt;
  logic wdata_prev, next_wdata_prev;
  logic [1:0] pulse_cnt, next_pulse_cnt;
  logic [TAPS-1:0] dline, next_dline;
  logic [3:0] tap, next_tap;
  logic next_wout;
  logic wclk, next_wclk;
  logic [1:0] rdiv, next_rdiv;
  logic vco_ext, next_vco_ext;
  logic pcen_prev, next_pcen_prev;
  logic raw_prev, next_raw_prev;
  logic rd_pulse, next_rd_pulse;
  logic [3:0] rd_cnt, next_rd_cnt;
  logic next_rdata, next_rclk, next_sync_out, next_ext_clk;
  logic next_block, next_up, next_dn, next_fb_open, next_clamp;
  wpc_mode_e mode, next_mode;
  logic ctrl_mfm, next_ctrl_mfm;
  logic [3:0] ctrl_ptap, next_ctrl_ptap;
  logic ap_wr, next_ap_wr;
  logic [31:0] ap_addr, next_ap_addr;
  logic [31:0] next_hrdata;

  // decoded inputs
  logic wg, rg, en, e_s, l_s, tsel_eff, sync_cfg, sync_pulse, wp, suppress, raw_rise;
  logic ap_take;
  wpc_mode_e dec_mode;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_sync1 = {freq_down_err, freq_up_err, phase_lock_flag, composite_read_gate,
                  raw_read_in, test_select, precomp_enable, read_gate, write_gate,
                  double_shift_sel, late_req, early_req, write_data_in};
    next_sync2 = sync1;
    wg = sync2[WPC_IN_WRITE_GATE];
    rg = sync2[WPC_IN_READ_GATE];
    en = sync2[WPC_IN_PCEN];
    e_s = sync2[WPC_IN_EARLY];
    l_s = sync2[WPC_IN_LATE];
    // sys_clk sees every edge of the divided write clock, so sampling each cycle
    // takes both write clock edges
    next_wr_cap = {sync2[WPC_IN_DSHIFT], l_s, e_s, sync2[WPC_IN_WDATA]}; // [R1]
    next_wr_rt = wr_cap; // [R2]
    // once the external VCO is latched the test select pin carries its clock
    tsel_eff = sync2[WPC_IN_TSEL] & ~vco_ext; // [R18]
    sync_cfg = ~e_s & ~l_s & wg;
    sync_pulse = sync_cfg & en; // [R13]
    next_pcen_prev = en;
    next_vco_ext = vco_ext;
    if (pcen_prev && !en && sync_cfg) begin
      next_vco_ext = rg; // [R17]
    end
    // test mode decode
    dec_mode = WPC_TM_NORMAL;
    if (!tsel_eff) begin
      unique case ({e_s, l_s, en}) // [R19]
        3'b000: dec_mode = WPC_TM_PHASE_DET;
        3'b001: dec_mode = wg ? WPC_TM_NORMAL : WPC_TM_ACQ_SEQ; // [R20]
        3'b010: dec_mode = WPC_TM_PUMP_UP_PD;
        3'b011: dec_mode = WPC_TM_PUMP_UP;
        3'b100: dec_mode = WPC_TM_PUMP_DN_PD;
        3'b101: dec_mode = WPC_TM_PUMP_DN;
        3'b110: dec_mode = WPC_TM_OPTICAL;
        3'b111: dec_mode = WPC_TM_NORMAL;
      endcase
    end
    next_mode = dec_mode;
    // write path
    next_wdata_prev = wr_rt[0];
    wp = wr_rt[0] & ~wdata_prev;
    suppress = ctrl_mfm & wp & (pulse_cnt == WPC_SUPPRESS_AT); // [R8]
    next_pulse_cnt = pulse_cnt;
    if (!wg) begin
      next_pulse_cnt = 2'h0; // [R24]
    end else if (wp && pulse_cnt != WPC_CNT_MAX) begin
      next_pulse_cnt = pulse_cnt + 2'h1;
    end
    next_tap = tap;
    if (wp) begin
      if (!en || (wr_rt[1] == wr_rt[2])) begin
        next_tap = WPC_TAP_NOMINAL; // [R4] [R6]
      end else if (wr_rt[1]) begin
        next_tap = WPC_TAP_NOMINAL - (wr_rt[3] ? WPC_TAP_TWO : WPC_TAP_ONE); // [R5] [R7]
      end else begin
        next_tap = WPC_TAP_NOMINAL + (wr_rt[3] ? WPC_TAP_TWO : WPC_TAP_ONE); // [R5] [R7]
      end
    end
    // each stage is one sixteenth of the line; tap picks the output stage
    next_dline = {dline[TAPS-2:0], wp & wg & ~suppress}; // [R3] [R9]
    next_wout = wg & dline[tap]; // [R3] [R24]
    // pulse former: width set by a tap count, not by the input pulse
    next_raw_prev = sync2[WPC_IN_RAW];
    raw_rise = sync2[WPC_IN_RAW] & ~raw_prev;
    next_rd_pulse = rd_pulse;
    next_rd_cnt = rd_cnt;
    if (raw_rise) begin
      next_rd_pulse = 1'b1; // [R10]
      next_rd_cnt = ctrl_ptap;
    end else if (rd_pulse) begin
      if (rd_cnt == 4'h0) begin
        next_rd_pulse = 1'b0; // [R10]
      end else begin
        next_rd_cnt = rd_cnt - 4'h1;
      end
    end
    // clocks
    next_wclk = sync_pulse ? 1'b1 : ~wclk; // [R12] [R14]
    next_rdiv = sync_pulse ? 2'h3 : rdiv + 2'h1;
    next_rdata = rd_pulse;
    next_rclk = rdiv[1];
    unique case (dec_mode)
      WPC_TM_OPTICAL: next_rclk = rdiv[0]; // [R21]
      WPC_TM_PHASE_DET, WPC_TM_PUMP_UP_PD, WPC_TM_PUMP_DN_PD: begin
        next_rdata = sync2[WPC_IN_FUP]; // [R22]
        next_rclk = sync2[WPC_IN_FDN];
      end
      WPC_TM_ACQ_SEQ: begin
        next_rdata = sync2[WPC_IN_CRG]; // [R20]
        next_rclk = sync2[WPC_IN_PHASE_LOCK_FLAG];
      end
      WPC_TM_NORMAL, WPC_TM_PUMP_UP, WPC_TM_PUMP_DN: begin
        next_rdata = rd_pulse;
        next_rclk = rdiv[1];
      end
    endcase
    if (sync_pulse) begin
      next_rclk = 1'b1; // [R14]
    end
    next_sync_out = sync_pulse; // [R14]
    next_ext_clk = vco_ext & sync2[WPC_IN_TSEL]; // [R18]
    next_up = (dec_mode == WPC_TM_PUMP_UP) || (dec_mode == WPC_TM_PUMP_UP_PD); // [R23]
    next_dn = (dec_mode == WPC_TM_PUMP_DN) || (dec_mode == WPC_TM_PUMP_DN_PD); // [R23]
    next_block = next_up | next_dn; // [R23]
    next_fb_open = next_block | vco_ext | sync_pulse; // [R23] [R14]
    next_clamp = next_block | vco_ext | sync_pulse; // [R23] [R14]
    // bus slave: writes land in the data phase, reads are set up at address phase
    ap_take = hsel & hready & (htrans == WPC_HTRANS_NONSEQ);
    next_ap_wr = ap_take & hwrite;
    next_ap_addr = ap_take ? haddr : ap_addr;
    next_ctrl_mfm = ctrl_mfm;
    next_ctrl_ptap = ctrl_ptap;
    if (ap_wr && is_reg(ap_addr, WPC_CTRL_ADDR)) begin
      next_ctrl_mfm = hwdata[WPC_CTRL_MFM_BIT];
      next_ctrl_ptap = hwdata[WPC_CTRL_PTAP_LSB +: 4];
    end
    next_hrdata = 32'h0000_0000;
    if (ap_take && !hwrite) begin
      if (is_reg(haddr, WPC_CTRL_ADDR)) begin
        next_hrdata[WPC_CTRL_MFM_BIT] = ctrl_mfm;
        next_hrdata[WPC_CTRL_PTAP_LSB +: 4] = ctrl_ptap;
      end else if (is_reg(haddr, WPC_STATUS_ADDR)) begin
        next_hrdata[WPC_ST_MODE_LSB +: 3] = mode;
        next_hrdata[WPC_ST_VCOEXT_BIT] = vco_ext;
        next_hrdata[WPC_ST_SYNC_BIT] = vco_div_clear;
        next_hrdata[WPC_ST_WRITE_GATE_BIT] = wg;
        next_hrdata[WPC_ST_CNT_LSB +: 2] = pulse_cnt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin // [R11]
      sync1 <= '0;
      sync2 <= '0;
      wr_cap <= 4'h0;
      wr_rt <= 4'h0;
      wdata_prev <= 1'b0;
      pulse_cnt <= 2'h0;
      dline <= '0;
      tap <= WPC_TAP_NOMINAL;
      precomp_write_out <= 1'b0;
      wclk <= 1'b0;
      rdiv <= 2'h0;
      vco_ext <= 1'b0;
      pcen_prev <= 1'b0;
      raw_prev <= 1'b0;
      rd_pulse <= 1'b0;
      rd_cnt <= 4'h0;
      mode <= WPC_TM_NORMAL;
      read_data_out <= 1'b0;
      read_clock_out <= 1'b0;
      vco_div_clear <= 1'b0;
      ext_vco_clock <= 1'b0;
      pd_data_block <= 1'b0;
      pump_force_up <= 1'b0;
      pump_force_down <= 1'b0;
      pump_feedback_open <= 1'b0;
      pump_clamp_defeat <= 1'b0;
      ctrl_mfm <= WPC_CTRL_MFM_RESET;
      ctrl_ptap <= WPC_CTRL_PTAP_RESET;
      ap_wr <= 1'b0;
      ap_addr <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      wr_cap <= next_wr_cap;
      wr_rt <= next_wr_rt;
      wdata_prev <= next_wdata_prev;
      pulse_cnt <= next_pulse_cnt;
      dline <= next_dline;
      tap <= next_tap;
      precomp_write_out <= next_wout;
      wclk <= next_wclk;
      rdiv <= next_rdiv;
      vco_ext <= next_vco_ext;
      pcen_prev <= next_pcen_prev;
      raw_prev <= next_raw_prev;
      rd_pulse <= next_rd_pulse;
      rd_cnt <= next_rd_cnt;
      mode <= next_mode;
      read_data_out <= next_rdata;
      read_clock_out <= next_rclk;
      vco_div_clear <= next_sync_out;
      ext_vco_clock <= next_ext_clk;
      pd_data_block <= next_block;
      pump_force_up <= next_up;
      pump_force_down <= next_dn;
      pump_feedback_open <= next_fb_open;
      pump_clamp_defeat <= next_clamp;
      ctrl_mfm <= next_ctrl_mfm;
      ctrl_ptap <= next_ctrl_ptap;
      ap_wr <= next_ap_wr;
      ap_addr <= next_ap_addr;
      hrdata <= next_hrdata;
    end
  end

  // the halt, phase detector reset, tristate and velocity lock effects come from one flop so they rise and fall together
  assign ring_osc_halt = vco_div_clear;
  assign phase_det_reset = vco_div_clear;
  assign pump_tristate = vco_div_clear;
  assign velocity_lock_state = vco_div_clear;
  assign write_clock_out = wclk;
  assign vco_external = vco_ext;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_nominal_when_off: assert property (wp && !en |=> tap == WPC_TAP_NOMINAL) // [R4]
    else $error("tap not nominal with precomp off");
  a_early_one_stage: assert property ( // [R5]
    wp && en && wr_rt[1] && !wr_rt[2] && !wr_rt[3] |=> tap == 4'h7)
    else $error("early single shift tap wrong");
  a_late_two_stage: assert property ( // [R7]
    wp && en && !wr_rt[1] && wr_rt[2] && wr_rt[3] |=> tap == 4'hA)
    else $error("late double shift tap wrong");
  a_both_nominal: assert property ( // [R6]
    wp && en && wr_rt[1] && wr_rt[2] |=> tap == WPC_TAP_NOMINAL)
    else $error("illegal early and late not nominal");
  a_third_suppressed: assert property ( // [R8]
    ctrl_mfm && wg && wp && pulse_cnt == 2'h2 |=> !dline[0] && pulse_cnt == 2'h3)
    else $error("third write pulse not suppressed");
  a_gate_idle: assert property (!wg |=> !precomp_write_out && pulse_cnt == 2'h0) // [R24]
    else $error("write output active with gate low");
  a_retime_pipe: assert property ( // [R2]
    wr_rt[0] == $past(sync2[WPC_IN_WDATA], 2))
    else $error("write data retime latency wrong");
  a_wclk_divide: assert property ( // [R12]
    !sync_pulse ##1 !sync_pulse |=> wclk != $past(wclk))
    else $error("write clock not divided by two");
  a_sync_forces: assert property ( // [R14]
    sync_pulse |=> wclk && read_clock_out && vco_div_clear && pump_clamp_defeat)
    else $error("reset pulse effects missing");
  a_vco_latch: assert property ( // [R17]
    pcen_prev && !en && sync_cfg |=> vco_ext == $past(rg))
    else $error("VCO select not latched at enable fall");
  a_phase_det_route: assert property ( // [R22]
    dec_mode == WPC_TM_PHASE_DET && !sync_pulse |=> read_data_out == $past(sync2[WPC_IN_FUP]))
    else $error("phase detector up error not routed");
  a_pulse_width: assert property ( // [R10]
    raw_rise && ctrl_ptap == 4'h4 ##1 !raw_rise [*5] |-> rd_pulse ##1 !rd_pulse)
    else $error("read pulse width not set by tap");

endmodule : wpc_ctrl
`default_nettype wire

// ---- tb/wpc_host_model.sv ----
// disk controller model driving the write-side pins of the controller
`default_nettype none
module wpc_host_model (
  input wire logic sys_clk, // crystal clock
  output logic write_data_in, // write data
  output logic early_req, // early shift request
  output logic late_req, // late shift request
  output logic double_shift_sel, // two-stage shift
  output logic write_gate, // write gate
  output logic read_gate, // read gate
  output logic precomp_enable // precompensation enable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {write_data_in, early_req, late_req, double_shift_sel} = 4'h0;
    {write_gate, read_gate, precomp_enable} = 3'h0;
  end
  // levels only change just after a rising edge
  task automatic set_pins(input logic wg, rg, e, l, d, en);
    write_gate <= wg;
    read_gate <= rg;
    early_req <= e;
    late_req <= l;
    double_shift_sel <= d;
    precomp_enable <= en;
  endtask : set_pins
  // one-cycle data pulse; shift requests stay put around it
  task automatic pulse();
    write_data_in <= 1'b1;
    @(posedge sys_clk);
    write_data_in <= 1'b0;
  endtask : pulse
  // read gate is held past the enable fall so the latch sees a stable level
  task automatic sync_pulse(input logic rg, input int len);
    set_pins(1'b1, rg, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (len) @(posedge sys_clk);
    precomp_enable <= 1'b0;
    repeat (4) @(posedge sys_clk);
    read_gate <= 1'b0;
  endtask : sync_pulse
endmodule : wpc_host_model
`default_nettype wire

// ---- tb/test_wpc_ctrl.sv ----
// self-checking bench for the precompensation and test-mode controller
`default_nettype none
module test_wpc_ctrl
  import wpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 20000; // run needs about 1300 cycles
  logic sys_clk, reset, hsel, hwrite, hready, hreadyout, hresp, rd_dp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic write_data_in, early_req, late_req, double_shift_sel, write_gate, read_gate;
  logic precomp_enable, test_select, raw_read_in, composite_read_gate, phase_lock_flag;
  logic freq_up_err, freq_down_err, write_clock_out, precomp_write_out, read_data_out;
  logic read_clock_out, vco_external, ext_vco_clock, vco_div_clear, ring_osc_halt;
  logic phase_det_reset, pump_tristate, velocity_lock_state, pd_data_block, pump_force_up;
  logic pump_force_down, pump_feedback_open, pump_clamp_defeat;
  int errors, tests_run, cyc, wc, rc, n;
  int exp_pulse[$];
  logic [31:0] exp_rd[$], exp_mask[$];

  wpc_ctrl #(.TAPS(WPC_DL_TAPS)) i_dut (
    .sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .write_data_in, .early_req, .late_req,
    .double_shift_sel, .write_gate, .read_gate, .precomp_enable, .test_select,
    .raw_read_in, .composite_read_gate, .phase_lock_flag, .freq_up_err, .freq_down_err,
    .write_clock_out, .precomp_write_out, .read_data_out, .read_clock_out,
    .vco_external, .ext_vco_clock, .vco_div_clear, .ring_osc_halt, .phase_det_reset,
    .pump_tristate, .velocity_lock_state, .pd_data_block, .pump_force_up,
    .pump_force_down, .pump_feedback_open, .pump_clamp_defeat);
  wpc_host_model i_host (.sys_clk, .write_data_in, .early_req, .late_req,
    .double_shift_sel, .write_gate, .read_gate, .precomp_enable);
  assign hready = hreadyout;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic wait_rdy();
    do @(posedge sys_clk); while (hready !== 1'b1);
  endtask : wait_rdy
  // one single word transfer; a read leaves its masked expectation as a note
  task automatic ahb(input logic wr, input logic [31:0] a, d, m);
    if (!wr) begin
      exp_rd.push_back(d & m);
      exp_mask.push_back(m);
    end
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= WPC_HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    wait_rdy();
    // select stays up; htrans idle ends the transfer
  endtask : ahb
  task automatic wr_pulse(input logic e, l, d, en, keep);
    logic [3:0] tap;
    logic [3:0] step;
    int t0;
    tap = WPC_TAP_NOMINAL;
    step = d ? WPC_TAP_TWO : WPC_TAP_ONE;
    if (en && e && !l) tap = tap - step;
    if (en && l && !e) tap = tap + step;
    i_host.set_pins(write_gate, 1'b0, e, l, d, en);
    @(posedge sys_clk);
    t0 = cyc;
    i_host.pulse();
    if (keep) exp_pulse.push_back(t0 + 7 + int'(tap));
    repeat (30) @(posedge sys_clk);
  endtask : wr_pulse
  task automatic toggles(input int cnt, output int w, output int r);
    logic pw, pr;
    w = 0;
    r = 0;
    @(negedge sys_clk);
    {pw, pr} = {write_clock_out, read_clock_out};
    repeat (cnt) begin
      @(negedge sys_clk);
      w += int'(write_clock_out !== pw);
      r += int'(read_clock_out !== pr);
      {pw, pr} = {write_clock_out, read_clock_out};
    end
    @(posedge sys_clk);
  endtask : toggles
  task automatic sync_run(input logic v);
    logic [8:0] sv;
    fork
      i_host.sync_pulse(v, 8);
      begin
        repeat (5) @(negedge sys_clk);
        sv = {write_clock_out, read_clock_out, vco_div_clear, ring_osc_halt,
          phase_det_reset, pump_tristate, velocity_lock_state, pump_feedback_open,
          pump_clamp_defeat};
        check("sync levels", 32'h0000_01FF, 32'(sv));
        @(negedge sys_clk);
        check("clocks held", 32'h0000_0003, {30'h0, write_clock_out, read_clock_out});
      end
    join
    repeat (4) @(negedge sys_clk);
    check("vco select", {31'h0, v}, {31'h0, vco_external});
    sv = {4'h0, vco_div_clear, ring_osc_halt, phase_det_reset, pump_tristate,
      velocity_lock_state};
    check("sync released", 32'h0, 32'(sv));
    @(posedge sys_clk);
  endtask : sync_run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    rd_dp <= hsel && hready && htrans == WPC_HTRANS_NONSEQ && !hwrite;
    if (cyc == LIMIT) begin
      errors++;
      stop_test();
    end
  end
  // compared in mid-cycle, where the registered outputs have settled
  always @(negedge sys_clk) begin
    if (rd_dp) begin
      check("hrdata", exp_rd.pop_front(), hrdata & exp_mask.pop_front());
      check("hresp", 32'h0, {31'h0, hresp});
    end
    if (precomp_write_out === 1'b1) begin
      if (exp_pulse.size() == 0) check("unexpected pulse", 32'h0, 32'(cyc));
      else check("pulse cycle", 32'(exp_pulse.pop_front()), 32'(cyc));
    end
  end

  initial begin
    {errors, tests_run, cyc, n} = 0;
    {reset, hsel, hwrite, rd_dp, htrans, hsize} = 9'b1000_00_010;
    {haddr, hwdata, rnd} = {64'h0, 32'ha618_d5a7};
    {test_select, raw_read_in, composite_read_gate, phase_lock_flag} = 4'b1000;
    {freq_up_err, freq_down_err} = 2'b00;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rnd = xs(rnd);
    ahb(1'b0, WPC_CTRL_ADDR, 32'h0000_0040, '1);
    ahb(1'b0, WPC_STATUS_ADDR, 32'h0, 32'h0000_0338);
    ahb(1'b1, 32'h0000_0008, rnd, '1);
    ahb(1'b0, WPC_CTRL_ADDR, 32'h0000_0040, '1);
    ahb(1'b0, 32'h0000_0008, 32'h0, '1);
    ahb(1'b1, WPC_CTRL_ADDR, rnd, '1);
    ahb(1'b0, WPC_CTRL_ADDR, rnd, 32'h0000_00F1);
    ahb(1'b1, WPC_CTRL_ADDR, 32'h0000_0040, '1);
    $display("test registers done");
    toggles(8, wc, rc);
    check("write clock toggles", 32'h8, 32'(wc));
    check("read clock toggles", 32'h4, 32'(rc));
    i_host.set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 16; i++) begin
      if (!(i[3] && !i[2] && !i[1])) wr_pulse(i[2], i[1], i[0], i[3], 1'b1);
    end
    repeat (6) begin
      rnd = xs(rnd);
      wr_pulse(rnd[0], rnd[1], rnd[2], rnd[3] & (rnd[0] | rnd[1]), 1'b1);
    end
    $display("test precompensation done");
    ahb(1'b1, WPC_CTRL_ADDR, 32'h0000_0041, '1);
    for (int r = 0; r < 2; r++) begin
      i_host.set_pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      repeat (4) @(posedge sys_clk);
      wr_pulse(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      i_host.set_pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      repeat (4) @(posedge sys_clk);
      for (int k = 0; k < 4 - r; k++) wr_pulse(1'b0, 1'b0, 1'b0, 1'b0, k != 2);
    end
    ahb(1'b1, WPC_CTRL_ADDR, 32'h0000_0040, '1);
    $display("test third pulse done");
    sync_run(1'b1);
    rnd = xs(rnd);
    freq_up_err <= rnd[0];
    repeat (8) @(negedge sys_clk);
    check("ext clock high", 32'h1, {31'h0, ext_vco_clock});
    check("select decoded low", {31'h0, rnd[0]}, {31'h0, read_data_out});
    @(posedge sys_clk);
    test_select <= 1'b0;
    repeat (8) @(negedge sys_clk);
    check("ext clock low", 32'h0, {31'h0, ext_vco_clock});
    @(posedge sys_clk);
    test_select <= 1'b1;
    sync_run(1'b0);
    $display("test sync and vco done");
    test_select <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      rnd = xs(rnd);
      i_host.set_pins(1'b0, 1'b0, c[2], c[1], 1'b0, c[0]);
      {freq_up_err, freq_down_err, composite_read_gate, phase_lock_flag} <= rnd[3:0];
      repeat (8) @(negedge sys_clk);
      if (c == 0 || c == 2 || c == 4) check("error outputs", 32'(rnd[3:2]),
        {30'h0, read_data_out, read_clock_out});
      if (c == 1) check("acq outputs", 32'(rnd[1:0]), {30'h0, read_data_out, read_clock_out});
      check("pump force", {30'h0, c == 2 || c == 3, c == 4 || c == 5},
        {30'h0, pump_force_up, pump_force_down});
      if (c != 1 && c != 2 && c != 4) check("pump block", (c == 3 || c == 5) ? 32'h7 : 32'h0,
        {29'h0, pd_data_block, pump_feedback_open, pump_clamp_defeat});
      toggles(8, wc, rc);
      if (c >= 6) check("read clock rate", (c == 6) ? 32'h8 : 32'h4, 32'(rc));
    end
    test_select <= 1'b1;
    i_host.set_pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("test modes done");
    for (int k = 0; k < 3; k++) begin
      if (k == 2) ahb(1'b1, WPC_CTRL_ADDR, 32'h0000_0090, '1);
      repeat (8) @(posedge sys_clk);
      n = 0;
      raw_read_in <= 1'b1;
      for (int j = 0; j < 40; j++) begin
        @(posedge sys_clk);
        n += int'(read_data_out === 1'b1);
        if (j == ((k == 0) ? 20 : 0)) raw_read_in <= 1'b0;
      end
      check("formed width", (k == 2) ? 32'd10 : 32'd5, 32'(n));
    end
    $display("test pulse former done");
    check("pulses left", 32'h0, 32'(exp_pulse.size()));
    stop_test();
  end
endmodule : test_wpc_ctrl
`default_nettype wire
